// File: bench/mscr_prog_model.sv
`timescale 1ns/1ps
module mscr_prog_model (
  input wire logic core_clk,
  output mscr_pkg::mscr_req_s prog_req,
  input wire logic [15:0] prog_rdata,
  input wire logic prog_rvalid
);
  initial prog_req = '0;
  // normalized coefficient to stored word
  function automatic logic [15:0] norm(input real x);
    return 16'($rtoi(x * 32768.0));
  endfunction
  // a released bus drops both strobes and shows the inverse of the last address and data, never a stale copy
  task automatic drop(input mscr_pkg::mscr_req_s r);
    @(posedge core_clk);
    #1 prog_req = '{1'b0, 1'b0, ~r.addr, ~r.wdata};
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1 prog_req = '{1'b1, 1'b0, a, d};
    drop(prog_req);
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int i;
    @(posedge core_clk);
    #1 prog_req = '{1'b0, 1'b1, a, 16'h0000};
    drop(prog_req);
    d = 16'hxxxx;
    // valid stands for one cycle after the taking edge, look at it settled
    for (i = 0; i < 4; i++)
    begin
      if (prog_rvalid === 1'b1)
      begin
        d = prog_rdata;
        break;
      end
      @(posedge core_clk);
      #1;
    end
  endtask
  // never trust a write until the status word says it landed
  task automatic wr_chk(input logic [4:0] a, input logic [15:0] d, output logic ok);
    logic [15:0] s;
    wr(a, d);
    rd(mscr_pkg::ADDR_STATUS, s);
    ok = (s[10:8] === 3'b000);
  endtask
endmodule // mscr_prog_model

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int P2K = 40;
  localparam int P1K = 80;
  localparam int P500 = 160;
  localparam int P250 = 320;
  logic core_clk, rst_n, ce, uv_pin, ov_pin, selftest_pin, ok;
  logic prog_rvalid, pwm_level, comm_en, error_active, memory_lock;
  mscr_pkg::mscr_req_s prog_req;
  mscr_pkg::mscr_prog_evt_s prog_evt;
  logic [21:0] decim_word;
  logic [15:0] field_in, temp_in, prog_rdata, raw, duty, rv;
  int errors, cmp_count, n, per;
  int rate_cyc [4] = '{P1K, P500, P250, P2K};

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  mscr_prog_model prg (.core_clk(core_clk), .prog_req(prog_req), .prog_rdata(prog_rdata),
    .prog_rvalid(prog_rvalid));

  mscr_top #(.P_2K_CYCLES(P2K), .P_1K_CYCLES(P1K), .P_500_CYCLES(P500), .P_250_CYCLES(P250)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .prog_req(prog_req), .prog_evt(prog_evt),
    .decim_word(decim_word), .factory_compensated_field(field_in), .calibrated_temperature(temp_in),
    .uv_pin(uv_pin), .ov_pin(ov_pin), .selftest_pin(selftest_pin), .prog_rdata(prog_rdata),
    .prog_rvalid(prog_rvalid), .raw_field_sample(raw), .duty_cycle(duty), .pwm_level(pwm_level),
    .pin_communication_enable(comm_en), .error_active(error_active), .memory_lock(memory_lock));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    settle(10);
    rst_n = 1'b1;
  endtask

  task automatic pulse(input mscr_pkg::mscr_prog_evt_s e);
    settle(1);
    prog_evt = e;
    settle(1);
    prog_evt = '0;
  endtask

  task automatic wait_err(input logic v);
    int i;
    for (i = 0; i < 20 && error_active !== v; i++) @(posedge core_clk);
    #1;
    check({15'h0000, error_active}, {15'h0000, v});
    if (error_active !== v) finish_test();
  endtask

  // highs over 200 cycles, after the running period has drained
  task automatic count_high(output int c);
    settle(400);
    c = 0;
    repeat (200)
    begin
      @(posedge core_clk);
      if (pwm_level === 1'b1) c++;
    end
  endtask

  // cycles between the second and third rising edge; first period may be stale
  task automatic period(output int c);
    int k, r;
    logic p;
    p = pwm_level;
    r = 0;
    c = 0;
    for (k = 0; k < 2000 && r < 3; k++)
    begin
      @(posedge core_clk);
      c++;
      if (p === 1'b0 && pwm_level === 1'b1)
      begin
        r++;
        if (r == 2) c = 0;
      end
      p = pwm_level;
    end
    #1;
    if (r < 3)
    begin
      errors++;
      finish_test();
    end
  endtask

  initial
  begin
    #400000;
    errors++;
    finish_test();
  end

  initial
  begin
    errors = 0;
    cmp_count = 0;
    ce = 1'b1;
    rst_n = 1'b0;
    prog_evt = '0;
    decim_word = 22'h00_0000;
    field_in = 16'h0000;
    temp_in = 16'h0000;
    uv_pin = 1'b0;
    ov_pin = 1'b0;
    selftest_pin = 1'b0;
    do_reset();
    prg.rd(mscr_pkg::ADDR_STATUS, rv);
    check(rv, 16'h0000);
    prg.wr(5'h0F, 16'hBEEF);
    prg.rd(5'h0F, rv);
    check(rv, 16'h0000);
    prg.wr_chk(mscr_pkg::ADDR_ID1, 16'hA5C3, ok);
    check({15'h0000, ok}, 16'h0001);
    prg.wr(mscr_pkg::ADDR_ID2, 16'h3C5A);
    prg.wr(mscr_pkg::ADDR_STATUS, 16'hFFFF);
    prg.rd(mscr_pkg::ADDR_ID1, rv);
    check(rv, 16'hA5C3);
    prg.rd(mscr_pkg::ADDR_ID2, rv);
    check(rv, 16'h3C5A);
    // a write taken while the clock enable is low must leave no trace
    ce = 1'b0;
    prg.wr(mscr_pkg::ADDR_ID2, 16'h0F0F);
    ce = 1'b1;
    prg.rd(mscr_pkg::ADDR_ID2, rv);
    check(rv, 16'h3C5A);
    for (n = 0; n < 3; n++)
    begin
      pulse(4'b0100 >> n);
      prg.rd(mscr_pkg::ADDR_STATUS, rv);
      check(rv, 16'h0400 >> n);
      pulse(4'b1000);
      prg.rd(mscr_pkg::ADDR_STATUS, rv);
      check(rv, 16'h0000);
    end
    prg.wr(mscr_pkg::ADDR_TCG0, prg.norm(0.5));
    prg.rd(mscr_pkg::ADDR_TCG0, rv);
    check(rv, 16'h4000);
    for (n = 0; n <= 6; n++)
    begin
      decim_word = 22'h00_0123 << (6 - n);
      prg.wr(mscr_pkg::ADDR_SETUP, 16'(n << 12));
      settle(3);
      check(raw, 16'h0123);
    end
    decim_word = 22'h01_0000;
    settle(3);
    check(raw, 16'h7FFF);
    decim_word = 22'h3F_0000;
    settle(3);
    check(raw, 16'h8000);
    decim_word = 22'h00_0000;
    prg.wr(mscr_pkg::ADDR_OOFF, 16'h7FFF);
    prg.wr(mscr_pkg::ADDR_CLHI, 16'h4000);
    settle(8);
    check(duty, 16'h4000);
    prg.wr(mscr_pkg::ADDR_CLHI, 16'h7FFF);
    prg.wr(mscr_pkg::ADDR_CLLO, 16'h5000);
    prg.wr(mscr_pkg::ADDR_OOFF, 16'h0000);
    settle(8);
    check(duty, 16'h5000);
    prg.wr(mscr_pkg::ADDR_CLLO, 16'h4000);
    prg.wr(mscr_pkg::ADDR_CLHI, 16'h4000);
    for (n = 0; n < 4; n++)
    begin
      prg.wr(mscr_pkg::ADDR_SETUP, 16'(n << 10));
      period(per);
      check(16'(per), 16'(rate_cyc[n]));
    end
    prg.wr(mscr_pkg::ADDR_SETUP, 16'h0010);
    settle(2);
    check({15'h0000, comm_en}, 16'h0001);
    prg.wr(mscr_pkg::ADDR_SETUP, 16'h0000);
    uv_pin = 1'b1;
    wait_err(1'b1);
    count_high(n);
    check(16'(n), 16'h00C8);
    uv_pin = 1'b0;
    wait_err(1'b0);
    prg.wr(mscr_pkg::ADDR_SETUP, 16'h0002);
    uv_pin = 1'b1;
    settle(20);
    check({15'h0000, error_active}, 16'h0000);
    prg.wr(mscr_pkg::ADDR_SETUP, 16'h0004);
    wait_err(1'b1);
    uv_pin = 1'b0;
    settle(20);
    check({15'h0000, error_active}, 16'h0001);
    do_reset();
    // overvoltage only counts while its disable bit is clear
    prg.wr(mscr_pkg::ADDR_SETUP, 16'h0008);
    ov_pin = 1'b1;
    settle(20);
    check({15'h0000, error_active}, 16'h0000);
    prg.wr(mscr_pkg::ADDR_SETUP, 16'h0000);
    wait_err(1'b1);
    ov_pin = 1'b0;
    selftest_pin = 1'b1;
    period(per);
    check(16'(per), 16'(2 * P1K));
    selftest_pin = 1'b0;
    wait_err(1'b0);
    prg.wr(mscr_pkg::ADDR_ID1, 16'h1111);
    prg.wr(mscr_pkg::ADDR_SETUP, 16'h0080);
    count_high(n);
    check(16'(n), 16'h0000);
    prg.wr(mscr_pkg::ADDR_SETUP, 16'h0081);
    prg.wr(mscr_pkg::ADDR_ID1, 16'h2222);
    prg.wr(mscr_pkg::ADDR_SETUP, 16'h0000);
    prg.rd(mscr_pkg::ADDR_ID1, rv);
    check(rv, 16'h1111);
    prg.rd(mscr_pkg::ADDR_SETUP, rv);
    check(rv, 16'h0081);
    check({15'h0000, memory_lock}, 16'h0001);
    count_high(n);
    check(16'(n), 16'h00C8);
    finish_test();
  end
endmodule // testbench

// File: logic/mscr_pkg.sv
package mscr_pkg;

  localparam int CLK_PERIOD_NS = 5;
  // pwm periods for the four rate settings
  localparam int PWM_2K_PERIOD_NS = 500000;
  localparam int PWM_1K_PERIOD_NS = 1000000;
  localparam int PWM_500_PERIOD_NS = 2000000;
  localparam int PWM_250_PERIOD_NS = 4000000;
  localparam int PWM_2K_CYCLES = PWM_2K_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PWM_1K_CYCLES = PWM_1K_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PWM_500_CYCLES = PWM_500_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PWM_250_CYCLES = PWM_250_PERIOD_NS / CLK_PERIOD_NS;

  // register indices on the programming port
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_ID1 = 5'h01;
  localparam logic [4:0] ADDR_ID2 = 5'h02;
  localparam logic [4:0] ADDR_TCG0 = 5'h03;
  localparam logic [4:0] ADDR_TCO0 = 5'h06;
  localparam logic [4:0] ADDR_SGAIN = 5'h08;
  localparam logic [4:0] ADDR_SOFF = 5'h09;
  localparam logic [4:0] ADDR_OGAIN = 5'h0A;
  localparam logic [4:0] ADDR_OOFF = 5'h0B;
  localparam logic [4:0] ADDR_CLHI = 5'h0C;
  localparam logic [4:0] ADDR_CLLO = 5'h0D;
  localparam logic [4:0] ADDR_SETUP = 5'h0E;
  localparam logic [4:0] ADDR_SETPT0 = 5'h10;

  // programming_error_status bits
  localparam int ST_PUMP = 10;
  localparam int ST_SUPPLY = 9;
  localparam int ST_NVRAM = 8;

  // customer_setup_word fields
  localparam int SU_RANGE_LSB = 12;
  localparam int SU_RATE_LSB = 10;
  localparam int SU_POL = 7;
  localparam int SU_COMM = 4;
  localparam int SU_OV_DIS = 3;
  localparam int SU_LATCH = 2;
  localparam int SU_NOERR = 1;
  localparam int SU_LOCK = 0;
  localparam logic [15:0] SETUP_MASK = 16'h7CBF;
  localparam logic [2:0] RANGE_MAX = 3'h6;

  localparam logic [1:0] RATE_2K = 2'h3;
  localparam logic [1:0] RATE_1K = 2'h0;
  localparam logic [1:0] RATE_500 = 2'h1;

  // diagnosis vector positions
  localparam int DG_UV = 3;
  localparam int DG_ST = 2;
  localparam int DG_OVF = 1;
  localparam int DG_OV = 0;

  // error duty levels, q15 of full scale
  localparam logic [15:0] DUTY_95 = 16'h799A;
  localparam logic [15:0] DUTY_85 = 16'h6CCD;
  localparam logic [15:0] DUTY_75 = 16'h6000;
  localparam logic [15:0] DUTY_FULL = 16'h7FFF;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mscr_req_s;

  typedef struct packed {
    logic write_start;
    logic pump_low;
    logic supply_low;
    logic nvram_fail;
  } mscr_prog_evt_s;

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] id1;
    logic [15:0] id2;
    logic [2:0][15:0] tcg;
    logic [1:0][15:0] tco;
    logic [15:0][15:0] linearization_points;
    logic [15:0] sgain;
    logic [15:0] soff;
    logic [15:0] ogain;
    logic [15:0] ooff;
    logic [15:0] clhi;
    logic [15:0] cllo;
    logic [15:0] setup;
    logic [15:0] raw;
    logic [15:0] cust;
    logic [15:0] scaled;
    logic [15:0] lin;
    logic [15:0] duty;
    logic ovf;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [3:0] diag;
    logic err;
    logic [21:0] cnt;
    logic [21:0] period;
    logic [21:0] thr;
    logic pwm;
    logic comm_en;
    logic [15:0] rdata;
    logic rvalid;
  } mscr_state_s;

  localparam mscr_state_s STATE_RESET = '0;

endpackage

// File: logic/mscr_top.sv
`timescale 1ns/1ps
// Operation
// [R01] status bit 10: programming voltage too low
// [R02] status bit 9: supply low during program
// [R03] status bit 8: nvram fail; 15:11 reserved
// [R04] programmer checks status or second acknowledge
// [R05] two 16-bit customer words stored unchanged
// [R06] pick 16-bit window from 22-bit word
// [R07] setting 0..6 shifts window down
// [R08] range setting from setup bits 14:12
// [R09] raw sample saturates, never wraps
// [R10] gain is second-order temperature polynomial
// [R11] programmer scales normalized coefficients by 32768
// [R12] offset is first-order temperature polynomial
// [R13] 16 differential setpoints, zeros give linear
// [R14] input scaling, linearizer input non-negative
// [R15] output gain and offset give duty
// [R16] duty clamped between low and high
// [R17] pwm rate from setup bits 11:10
// [R18] polarity bit 7, active only when locked
// [R19] setup bit 4 enables pin communication
// [R20] setup bit 2 latches diagnosis until reset
// [R21] setup bit 1 masks error signalling
// [R22] setup bit 0 locks memory
// [R23] lock is permanent, blocks all writes; rst_n clears it
// [R24] rate codes: 2k, 1k, 500, 250 Hz
// [R25] error: half rate, coded duty levels
// [R26] setup bit 3 disables overvoltage detection
module mscr_top #(
  parameter int unsigned P_2K_CYCLES = mscr_pkg::PWM_2K_CYCLES,
  parameter int unsigned P_1K_CYCLES = mscr_pkg::PWM_1K_CYCLES,
  parameter int unsigned P_500_CYCLES = mscr_pkg::PWM_500_CYCLES,
  parameter int unsigned P_250_CYCLES = mscr_pkg::PWM_250_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire mscr_pkg::mscr_req_s prog_req,
  input wire mscr_pkg::mscr_prog_evt_s prog_evt,
  input wire logic [21:0] decim_word,
  input wire logic [15:0] factory_compensated_field,
  input wire logic [15:0] calibrated_temperature,
  input wire logic uv_pin,
  input wire logic ov_pin,
  input wire logic selftest_pin,
  output logic [15:0] prog_rdata,
  output logic prog_rvalid,
  output logic [15:0] raw_field_sample,
  output logic [15:0] duty_cycle,
  output logic pwm_level,
  output logic pin_communication_enable,
  output logic error_active,
  output logic memory_lock
);

  mscr_pkg::mscr_state_s s_q;
  mscr_pkg::mscr_state_s s_d;

  function automatic logic signed [39:0] qmul(input logic signed [23:0] a, input logic signed [23:0] b);
    logic signed [47:0] p;
    p = a * b;
    qmul = 40'(p >>> 15);
  endfunction

  function automatic logic [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sd32767)
      sat16 = 16'h7FFF;
    else if (v < -40'sd32768)
      sat16 = 16'h8000;
    else
      sat16 = v[15:0];
  endfunction

  function automatic logic ovf16(input logic signed [39:0] v);
    ovf16 = (v > 40'sd32767) || (v < -40'sd32768);
  endfunction

  function automatic logic signed [23:0] sx(input logic [15:0] v);
    sx = 24'($signed(v));
  endfunction

  logic lock;
  logic wr_ok;
  logic [2:0] range;
  logic [1:0] rate;
  logic signed [39:0] shifted;
  logic signed [39:0] gain;
  logic signed [39:0] cust_v;
  logic signed [39:0] scaled_v;
  logic [15:0] xin;
  logic [3:0] seg;
  logic signed [39:0] lin_v;
  logic signed [39:0] out_v;
  logic [15:0] out_s;
  logic [15:0] duty_c;
  logic [3:0] diag_now;
  logic [15:0] duty_sel;
  logic [21:0] period_sel;
  logic wrap;
  logic pol_eff;
  logic [33:0] thr_prod;
  logic [11:0] duty_bits;

  assign lock = s_q.setup[mscr_pkg::SU_LOCK];
  assign range = s_q.setup[mscr_pkg::SU_RANGE_LSB +: 3];
  assign rate = s_q.setup[mscr_pkg::SU_RATE_LSB +: 2];
  // lock freezes every customer register, so only reset can clear the lock bit
  assign wr_ok = prog_req.wr && !lock && (prog_req.addr != mscr_pkg::ADDR_STATUS); // [R22] [R23]
  assign pol_eff = s_q.setup[mscr_pkg::SU_POL] & lock; // [R18]

  always_comb
  begin
    s_d = s_q;
    shifted = '0;
    gain = '0;
    cust_v = '0;
    scaled_v = '0;
    xin = '0;
    seg = '0;
    lin_v = '0;
    out_v = '0;
    out_s = '0;
    duty_c = '0;
    diag_now = '0;
    duty_sel = '0;
    period_sel = '0;
    wrap = 1'b0;
    thr_prod = '0;
    duty_bits = '0;

    // register writes
    if (wr_ok)
    begin
      if (prog_req.addr == mscr_pkg::ADDR_ID1)
        s_d.id1 = prog_req.wdata; // [R05]
      if (prog_req.addr == mscr_pkg::ADDR_ID2)
        s_d.id2 = prog_req.wdata; // [R05]
      if (prog_req.addr >= mscr_pkg::ADDR_TCG0 && prog_req.addr < mscr_pkg::ADDR_TCO0)
        s_d.tcg[prog_req.addr - mscr_pkg::ADDR_TCG0] = prog_req.wdata;
      if (prog_req.addr == mscr_pkg::ADDR_TCO0 || prog_req.addr == mscr_pkg::ADDR_TCO0 + 5'h01)
        s_d.tco[prog_req.addr[0]] = prog_req.wdata;
      if (prog_req.addr == mscr_pkg::ADDR_SGAIN)
        s_d.sgain = prog_req.wdata;
      if (prog_req.addr == mscr_pkg::ADDR_SOFF)
        s_d.soff = prog_req.wdata;
      if (prog_req.addr == mscr_pkg::ADDR_OGAIN)
        s_d.ogain = prog_req.wdata;
      if (prog_req.addr == mscr_pkg::ADDR_OOFF)
        s_d.ooff = prog_req.wdata;
      if (prog_req.addr == mscr_pkg::ADDR_CLHI)
        s_d.clhi = prog_req.wdata;
      if (prog_req.addr == mscr_pkg::ADDR_CLLO)
        s_d.cllo = prog_req.wdata;
      if (prog_req.addr == mscr_pkg::ADDR_SETUP)
        s_d.setup = prog_req.wdata & mscr_pkg::SETUP_MASK;
      if (prog_req.addr >= mscr_pkg::ADDR_SETPT0)
        s_d.linearization_points[prog_req.addr[3:0]] = prog_req.wdata;
    end

    // error flags clear at each new write, a same-cycle event still sets
    if (prog_evt.write_start)
      s_d.status = '0;
    if (prog_evt.pump_low)
      s_d.status[mscr_pkg::ST_PUMP] = 1'b1; // [R01]
    if (prog_evt.supply_low)
      s_d.status[mscr_pkg::ST_SUPPLY] = 1'b1; // [R02]
    if (prog_evt.nvram_fail)
      s_d.status[mscr_pkg::ST_NVRAM] = 1'b1; // [R03]

    s_d.rvalid = prog_req.rd;
    if (prog_req.rd)
    begin
      case (prog_req.addr)
        mscr_pkg::ADDR_STATUS: s_d.rdata = s_q.status; // [R03]
        mscr_pkg::ADDR_ID1: s_d.rdata = s_q.id1;
        mscr_pkg::ADDR_ID2: s_d.rdata = s_q.id2;
        mscr_pkg::ADDR_TCG0: s_d.rdata = s_q.tcg[0];
        mscr_pkg::ADDR_TCG0 + 5'h01: s_d.rdata = s_q.tcg[1];
        mscr_pkg::ADDR_TCG0 + 5'h02: s_d.rdata = s_q.tcg[2];
        mscr_pkg::ADDR_TCO0: s_d.rdata = s_q.tco[0];
        mscr_pkg::ADDR_TCO0 + 5'h01: s_d.rdata = s_q.tco[1];
        mscr_pkg::ADDR_SGAIN: s_d.rdata = s_q.sgain;
        mscr_pkg::ADDR_SOFF: s_d.rdata = s_q.soff;
        mscr_pkg::ADDR_OGAIN: s_d.rdata = s_q.ogain;
        mscr_pkg::ADDR_OOFF: s_d.rdata = s_q.ooff;
        mscr_pkg::ADDR_CLHI: s_d.rdata = s_q.clhi;
        mscr_pkg::ADDR_CLLO: s_d.rdata = s_q.cllo;
        mscr_pkg::ADDR_SETUP: s_d.rdata = s_q.setup;
        default: s_d.rdata = prog_req.addr[4] ? s_q.linearization_points[prog_req.addr[3:0]] : 16'h0000;
      endcase
    end

    // signal path, one register per stage
    shifted = 40'($signed(decim_word)) >>> (3'(mscr_pkg::RANGE_MAX) - (range > mscr_pkg::RANGE_MAX ?
      mscr_pkg::RANGE_MAX : range)); // [R06] [R07] [R08]
    s_d.raw = sat16(shifted); // [R09]
    gain = sx(s_q.tcg[0]) + qmul(sx(s_q.tcg[1]), sx(calibrated_temperature)) +
      qmul(sx(s_q.tcg[2]), 24'(qmul(sx(calibrated_temperature), sx(calibrated_temperature)))); // [R10]
    cust_v = qmul(sx(factory_compensated_field), 24'(gain)) + sx(s_q.tco[0]) +
      qmul(sx(s_q.tco[1]), sx(calibrated_temperature)); // [R12]
    s_d.cust = sat16(cust_v);
    scaled_v = qmul(sx(s_q.cust), sx(s_q.sgain)) + sx(s_q.soff); // [R14]
    s_d.scaled = sat16(scaled_v);
    xin = s_q.scaled[15] ? 16'h0000 : s_q.scaled; // [R14]
    seg = xin[14:11];
    lin_v = 40'($signed({1'b0, xin}));
    for (int j = 0; j < 16; j++)
    begin
      if (j < int'(seg))
        lin_v = lin_v + sx(s_q.linearization_points[j]); // [R13]
    end
    lin_v = lin_v + 40'((sx(s_q.linearization_points[seg]) * $signed({1'b0, xin[10:0]})) >>> 11); // [R13]
    s_d.lin = sat16(lin_v);
    out_v = qmul(sx(s_q.lin), sx(s_q.ogain)) + sx(s_q.ooff); // [R15]
    out_s = sat16(out_v);
    duty_c = out_s;
    if ($signed(duty_c) > $signed(s_q.clhi))
      duty_c = s_q.clhi; // [R16]
    if ($signed(duty_c) < $signed(s_q.cllo))
      duty_c = s_q.cllo; // [R16]
    if (duty_c[15])
      duty_c = 16'h0000;
    s_d.duty = duty_c;
    s_d.ovf = ovf16(cust_v) | ovf16(scaled_v) | ovf16(lin_v) | ovf16(out_v);

    // diagnosis
    s_d.sync1 = {uv_pin, ov_pin, selftest_pin};
    s_d.sync2 = s_q.sync1;
    diag_now[mscr_pkg::DG_UV] = s_q.sync2[2];
    diag_now[mscr_pkg::DG_OV] = s_q.sync2[1] & ~s_q.setup[mscr_pkg::SU_OV_DIS]; // [R26]
    diag_now[mscr_pkg::DG_ST] = s_q.sync2[0];
    diag_now[mscr_pkg::DG_OVF] = s_q.ovf;
    s_d.diag = s_q.setup[mscr_pkg::SU_LATCH] ? (s_q.diag | diag_now) : diag_now; // [R20]
    s_d.err = (|s_q.diag) & ~s_q.setup[mscr_pkg::SU_NOERR]; // [R21]

    // undervoltage outranks the others
    if (s_q.diag[mscr_pkg::DG_UV])
      duty_sel = mscr_pkg::DUTY_FULL; // [R25]
    else if (s_q.diag[mscr_pkg::DG_ST])
      duty_sel = mscr_pkg::DUTY_95; // [R25]
    else if (s_q.diag[mscr_pkg::DG_OVF])
      duty_sel = mscr_pkg::DUTY_85; // [R25]
    else
      duty_sel = mscr_pkg::DUTY_75; // [R25]
    if (!s_q.err)
      duty_sel = s_q.duty;

    case (rate)
      mscr_pkg::RATE_2K: period_sel = 22'(P_2K_CYCLES); // [R17] [R24]
      mscr_pkg::RATE_1K: period_sel = 22'(P_1K_CYCLES); // [R24]
      mscr_pkg::RATE_500: period_sel = 22'(P_500_CYCLES); // [R24]
      default: period_sel = 22'(P_250_CYCLES); // [R24]
    endcase
    if (s_q.err)
      period_sel = period_sel << 1; // [R25]

    // new period and duty taken only at a period boundary, no runt pulses
    wrap = (22'(s_q.cnt + 22'h00_0001) >= s_q.period);
    if (wrap)
    begin
      // 11-bit resolution at the fastest rate, 12-bit otherwise
      duty_bits = (rate == mscr_pkg::RATE_2K) ? {1'b0, duty_sel[14:4]} : duty_sel[14:3]; // [R24]
      thr_prod = (rate == mscr_pkg::RATE_2K) ? ((34'(period_sel) * 34'(duty_bits)) >> 11) :
        ((34'(period_sel) * 34'(duty_bits)) >> 12);
      s_d.thr = (duty_sel == mscr_pkg::DUTY_FULL) ? period_sel : thr_prod[21:0];
      s_d.period = period_sel;
      s_d.cnt = '0;
    end
    else
      s_d.cnt = 22'(s_q.cnt + 22'h00_0001);
    s_d.pwm = (s_d.cnt < s_d.thr) ^ pol_eff; // [R18]
    s_d.comm_en = s_q.setup[mscr_pkg::SU_COMM]; // [R19]
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      s_q <= mscr_pkg::STATE_RESET;
    else if (ce)
      s_q <= s_d;
  end

  assign prog_rdata = s_q.rdata;
  assign prog_rvalid = s_q.rvalid;
  assign raw_field_sample = s_q.raw;
  assign duty_cycle = s_q.duty;
  assign pwm_level = s_q.pwm;
  assign pin_communication_enable = s_q.comm_en;
  assign error_active = s_q.err;
  assign memory_lock = s_q.setup[mscr_pkg::SU_LOCK];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_pump;
    ce && prog_evt.pump_low |=> s_q.status[10];
  endproperty
  a_pump: assert property (p_pump) else $error("pump error bit not set"); // [R01]

  property p_supply;
    ce && prog_evt.supply_low |=> s_q.status[9];
  endproperty
  a_supply: assert property (p_supply) else $error("supply error bit not set"); // [R02]

  property p_nvram;
    ce && prog_evt.nvram_fail |=> s_q.status[8] && s_q.status[15:11] == 5'h00;
  endproperty
  a_nvram: assert property (p_nvram) else $error("nvram error bit wrong"); // [R03]

  property p_id;
    ce && wr_ok && prog_req.addr == mscr_pkg::ADDR_ID1 |=> s_q.id1 == $past(prog_req.wdata);
  endproperty
  a_id: assert property (p_id) else $error("customer word not stored"); // [R05]

  property p_range0;
    ce && range == 3'h0 |=> s_q.raw == $past(decim_word[21:6]);
  endproperty
  a_range0: assert property (p_range0) else $error("range 0 window wrong"); // [R07]

  property p_sat;
    ce && range == 3'h6 && !decim_word[21] && decim_word[21:16] != 6'h00 |=> s_q.raw == 16'h7FFF;
  endproperty
  a_sat: assert property (p_sat) else $error("raw sample did not saturate"); // [R09]

  property p_linpass;
    ce && s_q.linearization_points == '0 && !s_q.scaled[15] |=> s_q.lin == $past(s_q.scaled);
  endproperty
  a_linpass: assert property (p_linpass) else $error("zero setpoints not linear"); // [R13]

  property p_clamp;
    ce && $signed(s_q.cllo) >= 0 && $signed(s_q.cllo) <= $signed(s_q.clhi) ##1 $stable(s_q.clhi) && $stable(s_q.cllo)
      |-> $signed(s_q.duty) <= $signed(s_q.clhi) && $signed(s_q.duty) >= $signed(s_q.cllo);
  endproperty
  a_clamp: assert property (p_clamp) else $error("duty outside clamp band"); // [R16]

  property p_lock;
    s_q.setup[0] |=> s_q.setup[0] && $stable(s_q.id1) && $stable(s_q.setup);
  endproperty
  a_lock: assert property (p_lock) else $error("locked memory changed"); // [R23]

  property p_polarity;
    !lock && s_q.cnt == 22'h00_0000 && s_q.thr != 22'h00_0000 |-> s_q.pwm;
  endproperty
  a_polarity: assert property (p_polarity) else $error("unlocked period not starting high"); // [R18]

  property p_noerr;
    ce && s_q.setup[1] |=> !s_q.err;
  endproperty
  a_noerr: assert property (p_noerr) else $error("error mode despite mask"); // [R21]

  property p_errperiod;
    ce && s_q.err && rate == mscr_pkg::RATE_1K && wrap |=> s_q.period == 22'(2 * P_1K_CYCLES);
  endproperty
  a_errperiod: assert property (p_errperiod) else $error("error period not doubled"); // [R25]

  c_lock: cover property (ce && wr_ok && prog_req.addr == mscr_pkg::ADDR_SETUP && prog_req.wdata[0]);
  c_err: cover property (s_q.err && wrap);
  c_sat: cover property (s_q.raw == 16'h8000);
  c_read: cover property (s_q.rvalid && s_q.rdata != 16'h0000);

endmodule // mscr_top
